// ### logic/ckcf_regbank.sv
// Register bank for configuration bytes 4 to 10 of the clock generator.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Byte 4 bits 7..2 enable six differential outputs; read-write, reset 1.
// - Byte 4 bits 1,0 enable spread on synthesizers 1 and 2; reset 1.
// - Byte 5 bit 7 enables request A; ignored while 0; reset 0.
// - Byte 5 bit 6 routes request A to output 0 or 2; reset 0.
// - Byte 5 bits 5,4 enable request B, route to output 1 or 4.
// - Byte 5 bits 3,2 enable request C, route to output 0 or 2.
// - Byte 5 bits 1,0 enable request D, route to output 1 or 4.
// - Byte 6 bits 7,6 enable requests E,F gating outputs 6,8; reserved read 0.
// - Byte 6 bit 1 lets peripheral stop halt panel output 1; reset 0.
// - Byte 6 bit 0 lets peripheral stop halt serial output 0; reset 0.
// - Byte 7 is fixed: revision code high nibble, vendor code low.
// - Byte 8 bits 7..4 fixed device identifier; bits 3,2 read 0.
// - Byte 8 bits 1,0 enable the two 27 MHz outputs; reset 1.
// - Byte 9 bit 7 lets peripheral stop halt peripheral output 5.
// - Byte 9 bit 6 reads latched trusted strap; bit 5 reads 0.
// - Byte 9 bit 4 picks test output: 0 high-impedance, 1 divided reference.
// - Byte 9 bit 3 enters test mode, overriding the pin; reset 0.
// - Byte 9 bits 2..0 hold processor swing code; reset to 0.8V code.
// - Byte 10 bit 7 reads the 27 MHz select strap latched at start.
// - Byte 10 bits 6..2 make peripheral outputs 4..0 stoppable.
// - Byte 10 bits 1,0 make processor outputs stoppable; reset 1.
module ckcf_regbank #(
  parameter logic [3:0] REV_CODE = 4'ha,    // Arbitrary value.
  parameter logic [3:0] VENDOR_CODE = 4'h5, // Arbitrary value.
  parameter logic [3:0] PART_CODE = 4'h3    // Arbitrary value.
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic wr_stb_i,
  input wire logic rd_stb_i,
  input wire logic [7:0] index_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  input wire ckcf_pkg::ckcf_pins_t pins_i,
  output ckcf_pkg::ckcf_cfg_t cfg_o,
  output ckcf_pkg::ckcf_gate_t gate_o,
  output logic straps_valid_o
);

  function automatic logic in_bank(input logic [7:0] idx);
    in_bank = (idx >= ckcf_pkg::IDX_OUT_EN) && (idx <= ckcf_pkg::IDX_STOP_CTRL);
  endfunction

  function automatic logic [7:0] wmask(input logic [7:0] idx);
    unique case (idx)
      ckcf_pkg::IDX_OUT_EN: wmask = ckcf_pkg::WM_OUT_EN;
      ckcf_pkg::IDX_CLKREQ: wmask = ckcf_pkg::WM_CLKREQ;
      ckcf_pkg::IDX_REQEF_STOP: wmask = ckcf_pkg::WM_REQEF_STOP;
      ckcf_pkg::IDX_DEVID_27M: wmask = ckcf_pkg::WM_DEVID_27M;
      ckcf_pkg::IDX_TEST_SWING: wmask = ckcf_pkg::WM_TEST_SWING;
      ckcf_pkg::IDX_STOP_CTRL: wmask = ckcf_pkg::WM_STOP_CTRL;
      default: wmask = 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] rst_val(input logic [7:0] idx);
    unique case (idx)
      ckcf_pkg::IDX_OUT_EN: rst_val = ckcf_pkg::RST_OUT_EN;
      ckcf_pkg::IDX_CLKREQ: rst_val = ckcf_pkg::RST_CLKREQ;
      ckcf_pkg::IDX_REQEF_STOP: rst_val = ckcf_pkg::RST_REQEF_STOP;
      ckcf_pkg::IDX_DEVID_27M: rst_val = ckcf_pkg::RST_DEVID_27M;
      ckcf_pkg::IDX_TEST_SWING: rst_val = ckcf_pkg::RST_TEST_SWING;
      ckcf_pkg::IDX_STOP_CTRL: rst_val = ckcf_pkg::RST_STOP_CTRL;
      default: rst_val = 8'h00;
    endcase
  endfunction

  logic [7:0] regs_ff [4:10];
  ckcf_pkg::ckcf_pins_t pins_s1_ff;
  ckcf_pkg::ckcf_pins_t pins_s2_ff;
  logic trusted_ff;
  logic sel27_ff;
  logic latched_ff;
  logic [7:0] nxt_rdata;
  ckcf_pkg::ckcf_gate_t nxt_gate;
  logic [7:0] b4;
  logic [7:0] b5;
  logic [7:0] b6;
  logic [7:0] b8;
  logic [7:0] b9;
  logic [7:0] b10;
  logic [5:0] req_off;
  logic pstop;
  logic cstop;

  assign b4 = regs_ff[4];
  assign b5 = regs_ff[5];
  assign b6 = regs_ff[6];
  assign b8 = regs_ff[8];
  assign b9 = regs_ff[9];
  assign b10 = regs_ff[10];

  // Pins are asynchronous to the bus clock; only the second stage is read.
  // Reset to idle levels, since zeros would read as both stop inputs asserted.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pins_s1_ff <= ckcf_pkg::PINS_IDLE;
      pins_s2_ff <= ckcf_pkg::PINS_IDLE;
    end else begin
      pins_s1_ff <= pins_i;
      pins_s2_ff <= pins_s1_ff;
    end
  end

  // Straps are caught once, on the third edge after reset release, when the
  // synchroniser holds genuine pin values rather than its reset idle levels.
  logic [1:0] settle_ff;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      settle_ff <= 2'h0;
      latched_ff <= 1'b0;
      trusted_ff <= 1'b0;
      sel27_ff <= 1'b0;
    end else if (!latched_ff) begin
      settle_ff <= {settle_ff[0], 1'b1};
      if (settle_ff[1]) begin
        latched_ff <= 1'b1;
        trusted_ff <= pins_s2_ff.trusted_strap;
        sel27_ff <= pins_s2_ff.sel27_strap;
      end
    end
  end

  // Only writable bits change; reserved bits keep their reset zeros.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int i = 4; i <= 10; i++) begin
        regs_ff[i] <= rst_val(8'(i));
      end
    end else if (wr_stb_i && in_bank(index_i)) begin
      regs_ff[index_i[3:0]] <= (wdata_i & wmask(index_i))
        | (regs_ff[index_i[3:0]] & ~wmask(index_i));
    end
  end

  // Read data merges stored bits with fixed and latched fields.
  always_comb begin
    nxt_rdata = 8'h00;
    if (in_bank(index_i)) begin
      nxt_rdata = regs_ff[index_i[3:0]];
    end
    unique case (index_i)
      ckcf_pkg::IDX_VENDOR_REV: nxt_rdata = {REV_CODE, VENDOR_CODE};
      ckcf_pkg::IDX_DEVID_27M:
        nxt_rdata[7:ckcf_pkg::POS_HI_NIBBLE] = PART_CODE;
      ckcf_pkg::IDX_TEST_SWING: nxt_rdata[ckcf_pkg::POS_TRUSTED] = trusted_ff;
      ckcf_pkg::IDX_STOP_CTRL: nxt_rdata[ckcf_pkg::POS_SEL27] = sel27_ff;
      default: nxt_rdata = nxt_rdata;
    endcase
  end

  // One-cycle read answer; an index outside the bank returns zero.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rd_stb_i;
      if (rd_stb_i) begin
        rdata_o <= nxt_rdata;
      end
    end
  end

  // A request pin high means the endpoint released its clock.
  assign req_off = pins_s2_ff.clkreq_n;
  assign pstop = !pins_s2_ff.periph_stop_n;
  assign cstop = !pins_s2_ff.proc_stop_n;

  always_comb begin
    nxt_gate.serial_ref_run[0] = !((b5[7] && !b5[6] && req_off[0])
      || (b5[3] && !b5[2] && req_off[2])
      || (b6[0] && pstop));
    nxt_gate.serial_ref_run[1] = !((b5[5] && !b5[4] && req_off[1])
      || (b5[1] && !b5[0] && req_off[3])
      || (b6[1] && pstop));
    nxt_gate.serial_ref_run[2] = !((b5[7] && b5[6] && req_off[0])
      || (b5[3] && b5[2] && req_off[2]));
    nxt_gate.serial_ref_run[3] = !((b5[5] && b5[4] && req_off[1])
      || (b5[1] && b5[0] && req_off[3]));
    nxt_gate.serial_ref_run[4] = !(b6[7] && req_off[4]);
    nxt_gate.serial_ref_run[5] = !(b6[6] && req_off[5]);
    nxt_gate.periph_run[5] = !(b9[7] && pstop);
    nxt_gate.periph_run[4:0] = ~(b10[6:2] & {5{pstop}});
    nxt_gate.proc_run = ~(b10[1:0] & {2{cstop}});
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      gate_o <= '1;
    end else begin
      gate_o <= nxt_gate;
    end
  end

  assign straps_valid_o = latched_ff;
  assign cfg_o.out_en = b4[7:2];
  assign cfg_o.spread_en = b4[1:0];
  assign cfg_o.video27_en = b8[1:0];
  assign cfg_o.test_refn = b9[4];
  assign cfg_o.test_entry = b9[3];
  assign cfg_o.swing_code = b9[2:0];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  logic past_srst_ff;
  always_ff @(posedge clk_i) begin
    past_srst_ff <= srst_i;
  end

  reset_values_a: assert property (past_srst_ff && !srst_i |->
    cfg_o.out_en == 6'h3f && cfg_o.spread_en == 2'h3 && cfg_o.video27_en == 2'h3
    && cfg_o.swing_code == 3'h5 && !cfg_o.test_entry && !cfg_o.test_refn)
    else $error("Configuration not at reset values.");
  ro_write_a: assert property (wr_stb_i && index_i == 8'h07 ##1 rd_stb_i
    && index_i == 8'h07 |=> rdata_o == {REV_CODE, VENDOR_CODE})
    else $error("Fixed identity byte changed by a write.");
  rsvd_b6_a: assert property (rd_stb_i && index_i == 8'h06 |=>
    rdata_o[5:2] == 4'h0)
    else $error("Reserved bits of byte 6 not zero.");
  devid_a: assert property (rd_stb_i && index_i == 8'h08 |=>
    rdata_o[7:2] == {PART_CODE, 2'h0})
    else $error("Device identifier field wrong.");
  rw_write_a: assert property (wr_stb_i && index_i == 8'h04 ##1
    rd_stb_i && index_i == 8'h04 |=> rdata_o == $past(wdata_i, 2))
    else $error("Output enable byte did not store write.");
  trusted_rd_a: assert property (rd_stb_i && index_i == 8'h09 |=>
    rdata_o[6] == $past(trusted_ff) && !rdata_o[5])
    else $error("Trusted strap readback wrong.");
  periph_stop_a: assert property (b10[2] && pstop |=> !gate_o.periph_run[0])
    else $error("Peripheral output 0 did not stop.");
  proc_free_a: assert property (!b10[0] |=> gate_o.proc_run[0])
    else $error("Free-running processor output stopped.");
  req_ignore_a: assert property (!b5[7] && !b5[3] && !b6[0]
    |=> gate_o.serial_ref_run[0])
    else $error("Disabled request gated output 0.");
  req_route_a: assert property (b5[7] && b5[6] && req_off[0]
    |=> !gate_o.serial_ref_run[2])
    else $error("Request A not routed to output 2.");
  strap_hold_a: assert property (latched_ff |=> $stable(sel27_ff))
    else $error("Latched strap changed after start.");
  unmapped_a: assert property (rd_stb_i && !in_bank(index_i) |=> rdata_o == 8'h00)
    else $error("Unmapped index returned data.");
  gate_reset_a: assert property (past_srst_ff && !srst_i
    |=> gate_o == 14'h3fff)
    else $error("Output stopped right after reset.");

  // Requests A to D gate exactly the output that their route bit selects; E and F gate outputs 6 and 8.
  req_a_out0_a: assert property (b5[7] && !b5[6] && req_off[0]
    |=> !gate_o.serial_ref_run[0])
    else $error("Request A not routed to output 0.");
  req_b_out1_a: assert property (b5[5] && !b5[4] && req_off[1]
    |=> !gate_o.serial_ref_run[1])
    else $error("Request B not routed to output 1.");
  req_b_out4_a: assert property (b5[5] && b5[4] && req_off[1]
    |=> !gate_o.serial_ref_run[3])
    else $error("Request B not routed to output 4.");
  req_c_out0_a: assert property (b5[3] && !b5[2] && req_off[2]
    |=> !gate_o.serial_ref_run[0])
    else $error("Request C not routed to output 0.");
  req_c_out2_a: assert property (b5[3] && b5[2] && req_off[2]
    |=> !gate_o.serial_ref_run[2])
    else $error("Request C not routed to output 2.");
  req_d_out1_a: assert property (b5[1] && !b5[0] && req_off[3]
    |=> !gate_o.serial_ref_run[1])
    else $error("Request D not routed to output 1.");
  req_d_out4_a: assert property (b5[1] && b5[0] && req_off[3]
    |=> !gate_o.serial_ref_run[3])
    else $error("Request D not routed to output 4.");
  req_e_gate_a: assert property (b6[7] && req_off[4]
    |=> !gate_o.serial_ref_run[4])
    else $error("Request E did not gate output 6.");
  req_f_gate_a: assert property (b6[6] && req_off[5]
    |=> !gate_o.serial_ref_run[5])
    else $error("Request F did not gate output 8.");

  // A disabled request input must never stop anything.
  out2_free_a: assert property (!b5[7] && !b5[3]
    |=> gate_o.serial_ref_run[2])
    else $error("Output 2 stopped with its requests disabled.");
  out1_free_a: assert property (!b5[5] && !b5[1] && !b6[1]
    |=> gate_o.serial_ref_run[1])
    else $error("Output 1 stopped with its controls disabled.");
  out4_free_a: assert property (!b5[5] && !b5[1]
    |=> gate_o.serial_ref_run[3])
    else $error("Output 4 stopped with its requests disabled.");
  out6_free_a: assert property (!b6[7] |=> gate_o.serial_ref_run[4])
    else $error("Output 6 stopped with request E disabled.");
  out8_free_a: assert property (!b6[6] |=> gate_o.serial_ref_run[5])
    else $error("Output 8 stopped with request F disabled.");

  // Stop inputs act only on outputs whose stop-enable bit is set.
  panel_stop_a: assert property (b6[1] && pstop |=> !gate_o.serial_ref_run[1])
    else $error("Panel output 1 did not stop.");
  serial_stop_a: assert property (b6[0] && pstop |=> !gate_o.serial_ref_run[0])
    else $error("Serial output 0 did not stop.");
  periph5_stop_a: assert property (b9[7] && pstop |=> !gate_o.periph_run[5])
    else $error("Peripheral output 5 did not stop.");
  periph5_free_a: assert property (!b9[7] |=> gate_o.periph_run[5])
    else $error("Free-running peripheral output 5 stopped.");
  periph4_stop_a: assert property (b10[6] && pstop |=> !gate_o.periph_run[4])
    else $error("Peripheral output 4 did not stop.");
  periph4_free_a: assert property (!b10[6] |=> gate_o.periph_run[4])
    else $error("Free-running peripheral output 4 stopped.");
  proc1_stop_a: assert property (b10[1] && cstop |=> !gate_o.proc_run[1])
    else $error("Processor output 1 did not stop.");
  proc1_free_a: assert property (!b10[1] |=> gate_o.proc_run[1])
    else $error("Free-running processor output 1 stopped.");

  // Writable fields take the written value on the next edge and hold it otherwise; reserved bits ignore writes.
  out_en_store_a: assert property (wr_stb_i && index_i == 8'h04 && !wdata_i[7]
    |=> !cfg_o.out_en[5])
    else $error("Output enable bit 7 not cleared by write.");
  spread_store_a: assert property (wr_stb_i && index_i == 8'h04 && !wdata_i[0]
    |=> !cfg_o.spread_en[0])
    else $error("Spread enable not cleared by write.");
  video_store_a: assert property (wr_stb_i && index_i == 8'h08 && wdata_i[1]
    |=> cfg_o.video27_en[1])
    else $error("Plain 27 MHz enable not set by write.");
  test_sel_store_a: assert property (wr_stb_i && index_i == 8'h09 && wdata_i[4]
    |=> cfg_o.test_refn)
    else $error("Test output select not set by write.");
  test_entry_store_a: assert property (wr_stb_i && index_i == 8'h09 && !wdata_i[3]
    |=> !cfg_o.test_entry)
    else $error("Test entry not cleared by write.");
  swing_store_a: assert property (wr_stb_i && index_i == 8'h09
    && wdata_i[2:0] == 3'h5 |=> cfg_o.swing_code == 3'h5)
    else $error("Swing code not stored.");
  swing_hold_a: assert property (!(wr_stb_i && index_i == 8'h09)
    |=> $stable(cfg_o.swing_code))
    else $error("Swing code changed without a write.");
  rsvd_store_a: assert property (wr_stb_i && index_i == 8'h06
    |=> b6[5:2] == 4'h0)
    else $error("Reserved bits of byte 6 took a write.");

  // Fixed and latched fields read back unchanged.
  vendor_rd_a: assert property (rd_stb_i && index_i == 8'h07
    |=> rdata_o == {REV_CODE, VENDOR_CODE})
    else $error("Identity byte read wrong.");
  sel27_rd_a: assert property (rd_stb_i && index_i == 8'h0a
    |=> rdata_o[7] == $past(sel27_ff))
    else $error("Select strap readback wrong.");
  trusted_hold_a: assert property (latched_ff |=> $stable(trusted_ff))
    else $error("Latched trusted strap changed after start.");

  // Read answers come exactly one edge after the strobe and last one cycle.
  read_answer_a: assert property (rd_stb_i |=> rvalid_o)
    else $error("Read strobe not answered.");
  read_quiet_a: assert property (!rd_stb_i |=> !rvalid_o)
    else $error("Read answer without a strobe.");

  cov_write_cov: cover property (wr_stb_i && index_i == 8'h05 ##1 rd_stb_i);
  cov_pstop_cov: cover property (pstop && b6[0] ##1 !gate_o.serial_ref_run[0]);
  cov_req_cov: cover property (b6[7] && req_off[4] ##1 !gate_o.serial_ref_run[4]);
  cov_test_cov: cover property (cfg_o.test_entry && cfg_o.test_refn);
  cov_strap_cov: cover property (latched_ff && sel27_ff && !trusted_ff);

endmodule

`default_nettype wire

// ### pkg/ckcf_pkg.sv
// Shared constants and carrier types for the clock generator register bank.
package ckcf_pkg;

  // Byte indices of the bank.
  localparam logic [7:0] IDX_OUT_EN = 8'h04;
  localparam logic [7:0] IDX_CLKREQ = 8'h05;
  localparam logic [7:0] IDX_REQEF_STOP = 8'h06;
  localparam logic [7:0] IDX_VENDOR_REV = 8'h07;
  localparam logic [7:0] IDX_DEVID_27M = 8'h08;
  localparam logic [7:0] IDX_TEST_SWING = 8'h09;
  localparam logic [7:0] IDX_STOP_CTRL = 8'h0a;

  // Reset values of the writable bits.
  localparam logic [7:0] RST_OUT_EN = 8'hff;
  localparam logic [7:0] RST_CLKREQ = 8'h00;
  localparam logic [7:0] RST_REQEF_STOP = 8'h00;
  localparam logic [7:0] RST_DEVID_27M = 8'h03;
  localparam logic [7:0] RST_TEST_SWING = 8'h05;
  localparam logic [7:0] RST_STOP_CTRL = 8'h03;

  // Writable bit masks; every other bit is fixed, latched or reserved.
  localparam logic [7:0] WM_OUT_EN = 8'hff;
  localparam logic [7:0] WM_CLKREQ = 8'hff;
  localparam logic [7:0] WM_REQEF_STOP = 8'hc3;
  localparam logic [7:0] WM_DEVID_27M = 8'h03;
  localparam logic [7:0] WM_TEST_SWING = 8'h9f;
  localparam logic [7:0] WM_STOP_CTRL = 8'h7f;

  // Field positions that carry read-only content.
  localparam int POS_TRUSTED = 6;
  localparam int POS_SEL27 = 7;
  localparam int POS_HI_NIBBLE = 4;

  // Configuration carried to the clock output logic.
  typedef struct packed {
    logic [5:0] out_en;      // Byte 4 bits 7..2.
    logic [1:0] spread_en;   // Synth 1, synth 2.
    logic [1:0] video27_en;  // Plain, spread.
    logic [2:0] swing_code;
    logic test_entry;
    logic test_refn;
  } ckcf_cfg_t;

  // Run permissions; a 0 stops the named output.
  typedef struct packed {
    logic [5:0] serial_ref_run;  // Outputs 8, 6, 4, 2, 1, 0.
    logic [5:0] periph_run;      // Outputs 5..0.
    logic [1:0] proc_run;        // Outputs 1, 0.
  } ckcf_gate_t;

  // Pins from outside the clock domain.
  typedef struct packed {
    logic [5:0] clkreq_n;  // Requests F..A, active low.
    logic periph_stop_n;
    logic proc_stop_n;
    logic trusted_strap;
    logic sel27_strap;
  } ckcf_pins_t;

  // Idle pin levels with no stop asserted, so a synchroniser fresh out of reset
  // cannot stop an output before real pin values arrive.
  localparam ckcf_pins_t PINS_IDLE = '{clkreq_n: 6'h00, periph_stop_n: 1'b1,
    proc_stop_n: 1'b1, trusted_strap: 1'b0, sel27_strap: 1'b0};

endpackage

// ### bench/ckcf_host.sv
// Host model that moves indexed byte blocks to and from the register bank.
`timescale 1ns/10ps
`default_nettype none
module ckcf_host (
  input wire logic clk_i,
  output logic wr_stb_o,
  output logic rd_stb_o,
  output logic [7:0] index_o,
  output logic [7:0] wdata_o
);
  initial begin
    wr_stb_o = 1'b0;
    rd_stb_o = 1'b0;
    index_o = 8'h00;
    wdata_o = 8'h00;
  end
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d[$]);
    foreach (d[k]) begin
      @(negedge clk_i);
      wr_stb_o = wr;
      rd_stb_o = !wr;
      index_o = idx + 8'(k);
      wdata_o = d[k];
    end
    @(negedge clk_i);
    wr_stb_o = 1'b0;
    rd_stb_o = 1'b0;
    // Released lines carry junk, so a stale value can never pass for a live one.
    index_o = ~index_o;
    wdata_o = ~wdata_o;
  endtask
  // One byte written and read back on the very next edge, as the engine may do.
  task automatic wr_rd(input logic [7:0] idx, input logic [7:0] dat);
    @(negedge clk_i);
    wr_stb_o = 1'b1;
    index_o = idx;
    wdata_o = dat;
    @(negedge clk_i);
    wr_stb_o = 1'b0;
    rd_stb_o = 1'b1;
    @(negedge clk_i);
    rd_stb_o = 1'b0;
    index_o = ~index_o;
    wdata_o = ~wdata_o;
  endtask
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the clock generator register bank.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam logic [3:0] REV = 4'h6; // Arbitrary value.
  localparam logic [3:0] VEN = 4'h9; // Arbitrary value.
  localparam logic [3:0] PART = 4'hc; // Arbitrary value.
  logic clk_i;
  logic srst_i;
  logic wr_stb_i;
  logic rd_stb_i;
  logic [7:0] index_i;
  logic [7:0] wdata_i;
  logic [7:0] rdata_o;
  logic rvalid_o;
  logic straps_valid_o;
  ckcf_pkg::ckcf_pins_t pins_i;
  ckcf_pkg::ckcf_cfg_t cfg_o;
  ckcf_pkg::ckcf_gate_t gate_o;
  logic [7:0] sh[4:10];
  logic [7:0] exp_q[$];
  logic [7:0] q[$];
  logic [31:0] lfsr;
  int n_errors;
  int n_tests;

  ckcf_host i_host (.clk_i(clk_i), .wr_stb_o(wr_stb_i), .rd_stb_o(rd_stb_i),
    .index_o(index_i), .wdata_o(wdata_i));
  ckcf_regbank #(.REV_CODE(REV), .VENDOR_CODE(VEN), .PART_CODE(PART)) i_dut (
    .clk_i(clk_i), .srst_i(srst_i), .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i),
    .index_i(index_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .pins_i(pins_i), .cfg_o(cfg_o), .gate_o(gate_o), .straps_valid_o(straps_valid_o));

  // Readback is rebuilt from what was written, so fixed and reserved bits must mask out.
  function automatic logic [7:0] rb(input int i);
    case (i)
      4, 5: return sh[i];
      6: return sh[6] & 8'hc3;
      7: return {REV, VEN};
      8: return {PART, 2'h0, sh[8][1:0]};
      9: return (sh[9] & 8'h9f) | {1'b0, pins_i.trusted_strap, 6'h00};
      10: return (sh[10] & 8'h7f) | {pins_i.sel27_strap, 7'h00};
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input int i, input logic [7:0] d[$]);
    foreach (d[k]) begin
      if (i + k >= 4 && i + k <= 10) sh[i + k] = d[k];
    end
    i_host.xfer(1'b1, 8'(i), d);
  endtask
  task automatic rd(input int i, input int n);
    q = {};
    for (int k = 0; k < n; k++) begin
      exp_q.push_back(rb(i + k));
      q.push_back(8'h00);
    end
    i_host.xfer(1'b0, 8'(i), q);
    repeat (2) @(negedge clk_i);
    chk(cfg_o, {sh[4], sh[8][1:0], sh[9][2:0], sh[9][3], sh[9][4]}, "cfg");
  endtask
  task automatic wr_then_rd(input int i, input logic [7:0] d);
    if (i >= 4 && i <= 10) sh[i] = d;
    exp_q.push_back(rb(i));
    i_host.wr_rd(8'(i), d);
    repeat (2) @(negedge clk_i);
  endtask
  task automatic gate_is(input logic [13:0] e);
    repeat (4) @(negedge clk_i);
    chk(gate_o, e, "gate");
  endtask
  task automatic do_reset();
    srst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    srst_i = 1'b0;
    sh = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h03, 8'h05, 8'h03};
    for (int k = 0; k < 10 && straps_valid_o !== 1'b1; k++) @(negedge clk_i);
    chk(straps_valid_o, 64'h1, "straps");
    rd(4, 7);
    chk(gate_o, 14'h3fff, "gate");
    $display("test reset done");
  endtask
  task automatic final_report();
    if (exp_q.size() != 0) begin
      n_errors++;
      $display("BAD %0t %0d reads never answered", $time, exp_q.size());
    end
    $display("counts: tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(negedge clk_i) begin
    if (rvalid_o === 1'b1) begin
      chk(rdata_o, exp_q.size() > 0 ? exp_q.pop_front() : 9'h100, "read");
    end
  end
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    final_report();
  end
  initial begin
    int tgt;
    lfsr = 32'h7cff;
    n_errors = 0;
    n_tests = 0;
    pins_i = 10'h00e;
    do_reset();
    wr(4, '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff});
    rd(3, 9);
    wr_then_rd(4, 8'h5a);
    wr_then_rd(7, 8'h00);
    $display("test all ones done");
    repeat (3) begin
      q = {};
      repeat (7) begin
        lfsr = lfsr_step(lfsr);
        q.push_back(lfsr[7:0]);
      end
      wr(4, q);
      rd(4, 7);
    end
    $display("test random done");
    wr(9, '{8'h00, 8'h00});
    for (int k = 0; k < 8; k++) begin
      tgt = (k / 2) % 2 ? (k % 2 ? 3 : 1) : (k % 2 ? 2 : 0);
      wr(5, '{8'((2 | k % 2) << (6 - 2 * (k / 2)))});
      pins_i.clkreq_n = 6'(1 << (k / 2));
      gate_is({~(6'h01 << tgt), 8'hff});
      wr(5, '{8'((k % 2) << (6 - 2 * (k / 2)))});
      gate_is(14'h3fff);
      pins_i.clkreq_n = 6'h00;
    end
    wr(6, '{8'hc0});
    pins_i.clkreq_n = 6'h30;
    gate_is({6'h0f, 8'hff});
    pins_i.clkreq_n = 6'h00;
    $display("test requests done");
    wr(6, '{8'h03});
    wr(9, '{8'h85, 8'h5f});
    pins_i.periph_stop_n = 1'b0;
    gate_is({6'h3c, 6'h08, 2'b11});
    pins_i.proc_stop_n = 1'b0;
    gate_is({6'h3c, 6'h08, 2'b00});
    // Opposite strap levels for the second start, so each readback sees both.
    pins_i = 10'h00d;
    $display("test stops done");
    do_reset();
    final_report();
  end
endmodule
`default_nettype wire
